// File: spm_cpu_model.sv
// Behavioural CPU system that injects frames into the switch core.
// Assumes it is called just after a rising edge of the core clock.
`timescale 1ns/1ps
module spm_cpu_model (
    // Clock
    input wire logic i_clk,
    // Injection request
    output logic o_inj_valid,
    output logic o_inj_queue,
    output logic [11:0] o_inj_dst_mask
);
    initial begin
        o_inj_valid = 1'b0;
        o_inj_queue = 1'b0;
        o_inj_dst_mask = 12'h000;
    end
    // One pulse per frame; only two injection queues exist
    task automatic inject(input logic q, input logic [11:0] mask);
        o_inj_valid = 1'b1;
        o_inj_queue = q;
        o_inj_dst_mask = mask;
        @(posedge i_clk);
        #1;
        o_inj_valid = 1'b0;
        // Inverted leftovers expose a design that ignores valid
        o_inj_queue = ~q;
        o_inj_dst_mask = ~mask;
    endtask : inject
endmodule : spm_cpu_model

// File: spm_map_if.sv
// Carries the static port map between the map table and the top module.
// Assumes the table side is combinational and the user side registers it.
`timescale 1ns/1ps
interface spm_map_if;
    logic pcie_sel;
    logic [spm_pkg::NUM_PORTS-1:0][1:0] speed_req;
    logic [spm_pkg::NUM_PORTS-1:0] present;
    logic [spm_pkg::NUM_PORTS-1:0] pcs;
    logic [spm_pkg::NUM_PORTS-1:0][1:0] macro;
    logic [spm_pkg::NUM_PORTS-1:0] usable;
    logic [spm_pkg::NUM_PORTS-1:0] coding;
    logic [spm_pkg::NUM_PORTS-1:0] speed_err;

    modport table_side (
        input pcie_sel,
        input speed_req,
        output present,
        output pcs,
        output macro,
        output usable,
        output coding,
        output speed_err
    );
    modport user_side (
        output pcie_sel,
        output speed_req,
        input present,
        input pcs,
        input macro,
        input usable,
        input coding,
        input speed_err
    );
endinterface : spm_map_if

// File: spm_pkg.sv
// Constants for the switch port numbering and mapping block.
// Assumes one core clock domain; shared by the map table and the top module.
package spm_pkg;

    // Port numbering space
    localparam int NUM_PORTS = 12;
    localparam int PORT_W = 4;
    localparam logic [PORT_W-1:0] CPU_PORT = 4'hB;
    localparam logic [PORT_W-1:0] NODE_PROC_PORT = 4'hA;
    localparam logic [PORT_W-1:0] LAST_PORT = 4'hB;

    // CPU port module queues
    localparam int NUM_XTR_QUEUES = 8;
    localparam int NUM_INJ_QUEUES = 2;

    // Interception sources, lowest index wins when several hit
    localparam int NUM_ICPT_SRC = 5;
    localparam int ICPT_WELL_KNOWN = 0;
    localparam int ICPT_SECURITY = 1;
    localparam int ICPT_MAC_TABLE = 2;
    localparam int ICPT_VLAN_TABLE = 3;
    localparam int ICPT_LEARNING = 4;

    // Interface macro kinds
    typedef enum logic [1:0] {
        SPM_MACRO_NONE = 2'h0,
        SPM_MACRO_COPPER = 2'h1,
        SPM_MACRO_SLOW_SERIAL = 2'h2,
        SPM_MACRO_FAST_SERIAL = 2'h3
    } spm_macro_e;

    // Requested line speed per port
    typedef enum logic [1:0] {
        SPM_SPEED_100M = 2'h0,
        SPM_SPEED_1G = 2'h1,
        SPM_SPEED_2G5 = 2'h2,
        SPM_SPEED_RSVD = 2'h3
    } spm_speed_e;

    // Default macro per port, index = port number (6 and 9 unused, 11 internal)
    localparam logic [NUM_PORTS-1:0][1:0] DEFAULT_MACRO = {
        2'h0, 2'h3, 2'h0, 2'h3, 2'h3, 2'h0,
        2'h2, 2'h2, 2'h1, 2'h1, 2'h1, 2'h1
    };
    // Ports whose default module may run at 2.5 Gbps
    localparam logic [NUM_PORTS-1:0] DEFAULT_2G5_PORTS = 12'h400;
    // Fast lane index behind ports 7, 8 and 10
    localparam logic [NUM_PORTS-1:0][1:0] DEFAULT_FAST_LANE = {
        2'h0, 2'h2, 2'h0, 2'h1, 2'h0, 2'h0,
        2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0
    };
    // Fast lane that can be handed over to the PCIe endpoint
    localparam logic [1:0] PCIE_CAPABLE_LANE = 2'h2;

    // Serial coding reported per port
    localparam logic CODING_4B5B = 1'b0;
    localparam logic CODING_8B10B = 1'b1;

endpackage : spm_pkg

// File: spm_port_map.sv
// Combinational port map table: module, macro, PCS, coding and usability per port.
// Assumes the lane select and speed requests are steady core-clock signals.
`timescale 1ns/1ps
module spm_port_map (
    spm_map_if.table_side map
);

    // Walk the twelve ports against the default mapping
    // Per-port scratch is judged from the constant table, never from the outputs being built
    always_comb begin
        logic is_fast;
        logic lane_taken;
        is_fast = 1'b0;
        lane_taken = 1'b0;
        for (int p = 0; p < spm_pkg::NUM_PORTS; p++) begin
            map.macro[p] = spm_pkg::DEFAULT_MACRO[p];
            map.present[p] = (spm_pkg::DEFAULT_MACRO[p] != spm_pkg::SPM_MACRO_NONE);
            is_fast = (spm_pkg::DEFAULT_MACRO[p] == spm_pkg::SPM_MACRO_FAST_SERIAL);
            // Every module has a MAC; only high-speed serial modules add a PCS
            map.pcs[p] = (spm_pkg::DEFAULT_MACRO[p] == spm_pkg::SPM_MACRO_FAST_SERIAL);
            // Lane handed to PCIe leaves its port without an Ethernet interface
            lane_taken = is_fast && map.pcie_sel
                && (spm_pkg::DEFAULT_FAST_LANE[p] == spm_pkg::PCIE_CAPABLE_LANE);
            map.usable[p] = map.present[p] && !lane_taken;
            // 100BASE-FX uses 4B5B, every faster serial mode uses 8B10B
            map.coding[p] = (map.speed_req[p] == spm_pkg::SPM_SPEED_100M)
                ? spm_pkg::CODING_4B5B : spm_pkg::CODING_8B10B;
            // 2.5G only on a fast lane whose module is rated for it
            map.speed_err[p] = map.present[p] && (
                (map.speed_req[p] == spm_pkg::SPM_SPEED_RSVD)
                || ((map.speed_req[p] == spm_pkg::SPM_SPEED_2G5)
                    && !(is_fast && spm_pkg::DEFAULT_2G5_PORTS[p])));
        end
    end

endmodule : spm_port_map

// File: spm_switch_port_mapping.sv
// Port numbering and mapping stage of the switch core: filters forwarding masks
// to mapped ports, resolves logical ports, steers CPU interceptions and injections.
// Assumes all inputs come from core logic on i_clk; outputs are registered, one
// cycle after the request is presented.
`timescale 1ns/1ps
module spm_switch_port_mapping #(
    parameter int XTR_QUEUES = spm_pkg::NUM_XTR_QUEUES,
    parameter int INJ_QUEUES = spm_pkg::NUM_INJ_QUEUES,
    parameter int XTR_QW = $clog2(spm_pkg::NUM_XTR_QUEUES),
    parameter int INJ_QW = $clog2(spm_pkg::NUM_INJ_QUEUES)
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // Static configuration
    input wire logic i_lane_pcie_select,
    input wire logic [spm_pkg::NUM_PORTS-1:0][spm_pkg::PORT_W-1:0] i_logical_port_id,
    input wire logic [spm_pkg::NUM_ICPT_SRC-1:0][XTR_QW-1:0] i_xtr_queue_cfg,
    input wire logic [spm_pkg::NUM_PORTS-1:0][1:0] i_port_speed_req,
    // Frame descriptor from the forwarding decision
    input wire logic i_frm_valid,
    input wire logic [spm_pkg::PORT_W-1:0] i_frm_src_port,
    input wire logic [spm_pkg::NUM_PORTS-1:0] i_frm_dst_mask,
    input wire logic [spm_pkg::NUM_ICPT_SRC-1:0] i_icpt_copy,
    input wire logic [spm_pkg::NUM_ICPT_SRC-1:0] i_icpt_redir,
    // Injection request from the CPU system
    input wire logic i_inj_valid,
    input wire logic [INJ_QW-1:0] i_inj_queue,
    input wire logic [spm_pkg::NUM_PORTS-1:0] i_inj_dst_mask,
    // Forwarded frame result
    output logic o_fwd_valid,
    output logic [spm_pkg::NUM_PORTS-1:0] o_fwd_dst_mask,
    output logic [spm_pkg::PORT_W-1:0] o_fwd_logical_src,
    output logic o_fwd_src_drop,
    // Extraction toward the CPU port module
    output logic o_xtr_valid,
    output logic [XTR_QW-1:0] o_xtr_queue,
    output logic o_xtr_redirect,
    // Injected frame result
    output logic o_inj_fwd_valid,
    output logic [spm_pkg::NUM_PORTS-1:0] o_inj_fwd_dst_mask,
    output logic [INJ_QW-1:0] o_inj_fwd_queue,
    // Port map status
    output logic o_lane2_pcie,
    output logic [spm_pkg::NUM_PORTS-1:0] o_port_present,
    output logic [spm_pkg::NUM_PORTS-1:0] o_port_pcs,
    output logic [spm_pkg::NUM_PORTS-1:0][1:0] o_port_macro,
    output logic [spm_pkg::NUM_PORTS-1:0] o_port_usable,
    output logic [spm_pkg::NUM_PORTS-1:0] o_port_coding,
    output logic [spm_pkg::NUM_PORTS-1:0] o_port_speed_err
);

    // Refuse queue counts the CPU port module cannot serve
    if (XTR_QUEUES != spm_pkg::NUM_XTR_QUEUES || XTR_QW != $clog2(XTR_QUEUES)) begin : g_chk_xtr
        $error("Extraction queue count must be eight with matching width");
    end
    if (INJ_QUEUES != spm_pkg::NUM_INJ_QUEUES || INJ_QW != $clog2(INJ_QUEUES)) begin : g_chk_inj
        $error("Injection queue count must be two with matching width");
    end

    localparam logic [spm_pkg::NUM_PORTS-1:0] CPU_MASK = 12'h800;
    localparam logic [spm_pkg::NUM_PORTS-1:0] ZERO_MASK = 12'h000;
    localparam logic [spm_pkg::PORT_W-1:0] ZERO_PORT = 4'h0;
    localparam logic [XTR_QW-1:0] ZERO_XQ = '0;
    localparam logic [INJ_QW-1:0] ZERO_IQ = '0;

    // Map table
    spm_map_if map_bus ();

    assign map_bus.pcie_sel = i_lane_pcie_select;
    assign map_bus.speed_req = i_port_speed_req;

    spm_port_map u_map (
        .map(map_bus)
    );

    // Destinations a frame may reach: mapped usable ports plus the internal CPU port
    logic [spm_pkg::NUM_PORTS-1:0] fwd_allowed;
    assign fwd_allowed = map_bus.usable | CPU_MASK;

    // Source port validity: inside 0..11 and either a live module or the CPU port
    logic src_in_range;
    logic src_ok;
    assign src_in_range = (i_frm_src_port <= spm_pkg::LAST_PORT);
    always_comb begin
        src_ok = 1'b0;
        if (src_in_range) begin
            src_ok = (i_frm_src_port == spm_pkg::CPU_PORT)
                || map_bus.usable[i_frm_src_port[spm_pkg::PORT_W-1:0]];
        end
    end

    // Interception: any copy or redirect hit sends the frame to the CPU
    logic [spm_pkg::NUM_ICPT_SRC-1:0] icpt_hit;
    logic icpt_any;
    logic icpt_redir_any;
    logic [XTR_QW-1:0] xtr_queue_sel;
    assign icpt_hit = i_icpt_copy | i_icpt_redir;
    assign icpt_any = |icpt_hit;
    assign icpt_redir_any = |i_icpt_redir;

    // Lowest-numbered hitting source picks the queue from its own setting
    always_comb begin
        xtr_queue_sel = ZERO_XQ;
        for (int s = spm_pkg::NUM_ICPT_SRC - 1; s >= 0; s--) begin
            if (icpt_hit[s]) begin
                xtr_queue_sel = i_xtr_queue_cfg[s];
            end
        end
    end

    // Final destination mask: redirect removes front ports, copy adds the CPU port
    logic [spm_pkg::NUM_PORTS-1:0] dst_d;
    always_comb begin
        dst_d = i_frm_dst_mask & fwd_allowed & ~CPU_MASK;
        if (icpt_redir_any) begin
            dst_d = ZERO_MASK;
        end
        if (icpt_any) begin
            dst_d = dst_d | CPU_MASK;
        end
        // A frame never returns to the front port it came in on; a CPU-port source keeps its CPU bit
        if (src_in_range) begin
            dst_d[i_frm_src_port] = dst_d[i_frm_src_port]
                & (i_frm_src_port == spm_pkg::CPU_PORT);
        end
    end

    // Logical source: aggregated members share the id software gave them
    logic [spm_pkg::PORT_W-1:0] logical_src_d;
    always_comb begin
        logical_src_d = ZERO_PORT;
        if (src_in_range) begin
            logical_src_d = i_logical_port_id[i_frm_src_port];
        end
    end

    // Forwarding result; a bad source drops the frame and clears its destinations
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_fwd_valid <= 1'b0;
            o_fwd_dst_mask <= ZERO_MASK;
            o_fwd_logical_src <= ZERO_PORT;
            o_fwd_src_drop <= 1'b0;
        end else begin
            o_fwd_valid <= i_frm_valid;
            o_fwd_dst_mask <= (i_frm_valid && src_ok) ? dst_d : ZERO_MASK;
            o_fwd_logical_src <= i_frm_valid ? logical_src_d : ZERO_PORT;
            o_fwd_src_drop <= i_frm_valid && !src_ok;
        end
    end

    // Extraction request toward one of the eight CPU queues
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_xtr_valid <= 1'b0;
            o_xtr_queue <= ZERO_XQ;
            o_xtr_redirect <= 1'b0;
        end else begin
            o_xtr_valid <= i_frm_valid && src_ok && icpt_any;
            o_xtr_queue <= (i_frm_valid && icpt_any) ? xtr_queue_sel : ZERO_XQ;
            o_xtr_redirect <= i_frm_valid && src_ok && icpt_redir_any;
        end
    end

    // Injected frames enter on the CPU port; they may reach any live front port
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_inj_fwd_valid <= 1'b0;
            o_inj_fwd_dst_mask <= ZERO_MASK;
            o_inj_fwd_queue <= ZERO_IQ;
        end else begin
            o_inj_fwd_valid <= i_inj_valid;
            o_inj_fwd_dst_mask <= i_inj_valid
                ? (i_inj_dst_mask & map_bus.usable) : ZERO_MASK;
            o_inj_fwd_queue <= i_inj_valid ? i_inj_queue : ZERO_IQ;
        end
    end

    // Registered copy of the map, so status outputs come straight from flops
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_lane2_pcie <= 1'b0;
            o_port_present <= ZERO_MASK;
            o_port_pcs <= ZERO_MASK;
            o_port_macro <= '0;
            o_port_usable <= ZERO_MASK;
            o_port_coding <= ZERO_MASK;
            o_port_speed_err <= ZERO_MASK;
        end else begin
            o_lane2_pcie <= i_lane_pcie_select;
            o_port_present <= map_bus.present;
            o_port_pcs <= map_bus.pcs;
            o_port_macro <= map_bus.macro;
            o_port_usable <= map_bus.usable;
            o_port_coding <= map_bus.coding;
            o_port_speed_err <= map_bus.speed_err;
        end
    end

endmodule : spm_switch_port_mapping

// File: spm_switch_port_mapping_checker.sv
// Concurrent checks on the top-level ports of the port mapping stage.
// Assumes one core clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module spm_switch_port_mapping_checker #(
    parameter int XTR_QW = 3,
    parameter int INJ_QW = 1
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // Requests
    input wire logic i_frm_valid,
    input wire logic [4:0] i_icpt_copy,
    input wire logic [4:0] i_icpt_redir,
    input wire logic [4:0][XTR_QW-1:0] i_xtr_queue_cfg,
    input wire logic i_inj_valid,
    input wire logic [INJ_QW-1:0] i_inj_queue,
    // Results
    input wire logic o_fwd_valid,
    input wire logic [11:0] o_fwd_dst_mask,
    input wire logic o_xtr_valid,
    input wire logic [XTR_QW-1:0] o_xtr_queue,
    input wire logic o_inj_fwd_valid,
    input wire logic [11:0] o_inj_fwd_dst_mask,
    input wire logic [INJ_QW-1:0] o_inj_fwd_queue,
    input wire logic o_lane2_pcie,
    input wire logic [11:0] o_port_usable
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    // Frames with and without an interception hit
    sequence s_frm_no_hit;
        i_frm_valid && (i_icpt_copy | i_icpt_redir) == 5'h00;
    endsequence
    sequence s_frm_first_src;
        i_frm_valid && i_icpt_copy[0];
    endsequence
    a_fwd_one_late: assert property (i_frm_valid |=> o_fwd_valid)
        else $error("forward pulse missing");
    a_fwd_no_extra: assert property (!i_frm_valid |=> !o_fwd_valid && !o_xtr_valid)
        else $error("forward pulse without frame");
    a_unused_not_fwd: assert property (o_fwd_valid |-> (o_fwd_dst_mask & 12'h240) == 12'h000)
        else $error("unused port forwarded");
    a_cpu_only_icpt: assert property (s_frm_no_hit |=> !o_xtr_valid && !o_fwd_dst_mask[11])
        else $error("cpu port reached without hit");
    a_xtr_queue_pick: assert property (s_frm_first_src |=> !o_xtr_valid || o_xtr_queue == $past(i_xtr_queue_cfg[0]))
        else $error("extraction queue wrong");
    a_inj_queue_kept: assert property (i_inj_valid |=> o_inj_fwd_valid && o_inj_fwd_queue == $past(i_inj_queue))
        else $error("injection result wrong");
    a_inj_no_cpu: assert property (o_inj_fwd_valid |-> (o_inj_fwd_dst_mask & 12'hA40) == 12'h000)
        else $error("injection to cpu or unused port");
    a_pcie_blocks_npi: assert property (o_lane2_pcie |-> !o_port_usable[10])
        else $error("port 10 usable under pcie");
endmodule : spm_switch_port_mapping_checker

bind spm_switch_port_mapping spm_switch_port_mapping_checker #(.XTR_QW(XTR_QW), .INJ_QW(INJ_QW))
    u_spm_switch_port_mapping_checker (.i_clk, .i_nrst, .i_frm_valid, .i_icpt_copy, .i_icpt_redir,
    .i_xtr_queue_cfg, .i_inj_valid, .i_inj_queue, .o_fwd_valid, .o_fwd_dst_mask, .o_xtr_valid, .o_xtr_queue,
    .o_inj_fwd_valid, .o_inj_fwd_dst_mask, .o_inj_fwd_queue, .o_lane2_pcie, .o_port_usable);

// File: spm_switch_port_mapping_tb_top.sv
// Self-checking bench for the port mapping stage with a CPU injection model.
// Assumes a 125 MHz core clock; inputs change 1 ns after each rising edge.
`timescale 1ns/1ps
module spm_switch_port_mapping_tb_top;
    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_lane_pcie_select = 1'b0;
    logic [11:0][3:0] i_logical_port_id;
    logic [4:0][2:0] i_xtr_queue_cfg;
    logic [11:0][1:0] i_port_speed_req, o_port_macro;
    logic i_frm_valid = 1'b0;
    logic [3:0] i_frm_src_port = 4'h0;
    logic [11:0] i_frm_dst_mask = 12'h000;
    logic [4:0] i_icpt_copy = 5'h00;
    logic [4:0] i_icpt_redir = 5'h00;
    logic i_inj_valid, i_inj_queue, o_fwd_valid, o_fwd_src_drop, o_xtr_valid, o_xtr_redirect;
    logic o_inj_fwd_valid, o_inj_fwd_queue, o_lane2_pcie;
    logic [11:0] i_inj_dst_mask, o_fwd_dst_mask, o_inj_fwd_dst_mask, o_port_present, o_port_pcs;
    logic [11:0] o_port_usable, o_port_coding, o_port_speed_err;
    logic [3:0] o_fwd_logical_src;
    logic [2:0] o_xtr_queue;
    int fails = 0;
    int compares = 0;

    spm_switch_port_mapping u_spm_switch_port_mapping (.i_clk, .i_nrst, .i_lane_pcie_select, .i_logical_port_id,
        .i_xtr_queue_cfg, .i_port_speed_req, .i_frm_valid, .i_frm_src_port, .i_frm_dst_mask, .i_icpt_copy,
        .i_icpt_redir, .i_inj_valid, .i_inj_queue, .i_inj_dst_mask, .o_fwd_valid, .o_fwd_dst_mask,
        .o_fwd_logical_src, .o_fwd_src_drop, .o_xtr_valid, .o_xtr_queue, .o_xtr_redirect, .o_inj_fwd_valid,
        .o_inj_fwd_dst_mask, .o_inj_fwd_queue, .o_lane2_pcie, .o_port_present, .o_port_pcs, .o_port_macro,
        .o_port_usable, .o_port_coding, .o_port_speed_err);
    spm_cpu_model u_spm_cpu_model (.i_clk, .o_inj_valid(i_inj_valid), .o_inj_queue(i_inj_queue),
        .o_inj_dst_mask(i_inj_dst_mask));

    always #4 i_clk = ~i_clk;

    task automatic chk(input string nm, input logic [23:0] got, input logic [23:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic test_done;
        if (fails == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done

    task automatic tick;
        @(posedge i_clk);
        #1;
    endtask : tick

    // One frame; queue is judged only on extraction, logical id only on a kept source
    task automatic frm(input logic [3:0] src, input logic [11:0] dst, input logic [4:0] cp, input logic [4:0] rd,
                       input logic [11:0] e_dst, input logic e_drop, input logic e_xv, input logic [2:0] e_q);
        logic [23:0] m;
        m = {16'hFFFF, e_drop ? 4'h0 : 4'hF, e_xv ? 3'h7 : 3'h0, 1'b0};
        tick();
        i_frm_src_port = src;
        i_frm_dst_mask = dst;
        i_icpt_copy = cp;
        i_icpt_redir = rd;
        i_frm_valid = 1'b1;
        tick();
        i_frm_valid = 1'b0;
        chk("frame", {o_fwd_valid, o_fwd_src_drop, o_xtr_valid, o_xtr_redirect, o_fwd_dst_mask,
            o_fwd_logical_src, o_xtr_queue, 1'b0} & m,
            {1'b1, e_drop, e_xv, |rd, e_dst, i_logical_port_id[src], e_q, 1'b0} & m);
    endtask : frm

    task automatic injchk(input logic q, input logic [11:0] mask, input logic [11:0] e_mask);
        tick();
        u_spm_cpu_model.inject(q, mask);
        chk("inject", {10'h000, o_inj_fwd_valid, o_inj_fwd_queue, o_inj_fwd_dst_mask},
            {10'h000, 1'b1, q, e_mask});
    endtask : injchk

    task automatic t_defaults;
        tick();
        chk("present_pcs", {o_port_present, o_port_pcs}, 24'h5BF580);
        chk("macro", o_port_macro, 24'h33CA55);
        chk("usable_err", {o_port_usable, o_port_speed_err}, 24'h5BF000);
        injchk(1'b1, 12'hFFF, 12'h5BF);
    endtask : t_defaults

    task automatic t_frames;
        for (int s = 0; s < 5; s++) frm(4'h0, 12'h0FF, 5'(5'h1F << s), 5'h00, 12'h8BE, 1'b0, 1'b1, 3'(s + 3));
        frm(4'h4, 12'h0FF, 5'h00, 5'h10, 12'h800, 1'b0, 1'b1, 3'h7);
        frm(4'h1, 12'hFFF, 5'h00, 5'h00, 12'h5BD, 1'b0, 1'b0, 3'h0);
        frm(4'hB, 12'h001, 5'h00, 5'h00, 12'h001, 1'b0, 1'b0, 3'h0);
        frm(4'h9, 12'h0FF, 5'h01, 5'h00, 12'h000, 1'b1, 1'b0, 3'h0);
        frm(4'hC, 12'h0FF, 5'h01, 5'h00, 12'h000, 1'b1, 1'b0, 3'h0);
        i_logical_port_id[5] = 4'h4;
        frm(4'h5, 12'h010, 5'h00, 5'h00, 12'h010, 1'b0, 1'b0, 3'h0);
    endtask : t_frames

    task automatic t_pcie;
        i_lane_pcie_select = 1'b1;
        tick();
        chk("pcie", {11'h000, o_lane2_pcie, o_port_usable}, 24'h0011BF);
        frm(4'hA, 12'h001, 5'h01, 5'h00, 12'h000, 1'b1, 1'b0, 3'h0);
        frm(4'h0, 12'h400, 5'h00, 5'h00, 12'h000, 1'b0, 1'b0, 3'h0);
        injchk(1'b0, 12'hFFF, 12'h1BF);
        i_lane_pcie_select = 1'b0;
    endtask : t_pcie

    task automatic t_speed;
        i_port_speed_req[7] = 2'h2;
        i_port_speed_req[0] = 2'h3;
        i_port_speed_req[4] = 2'h0;
        tick();
        chk("speed", {o_port_speed_err, 10'h000, o_port_coding[5:4]}, {12'h081, 10'h000, 2'b10});
    endtask : t_speed

    // Start-up values, reset, then the scenarios
    initial begin
        for (int p = 0; p < 12; p++) begin
            i_logical_port_id[p] = 4'(p);
            i_port_speed_req[p] = 2'h1;
        end
        i_port_speed_req[10] = 2'h2;
        for (int s = 0; s < 5; s++) i_xtr_queue_cfg[s] = 3'(s + 3);
        repeat (6) @(posedge i_clk);
        #1;
        i_nrst = 1'b1;
        t_defaults();
        t_frames();
        t_pcie();
        t_speed();
        test_done();
    end

    // Hang guard
    initial begin
        #100000;
        fails++;
        test_done();
    end
endmodule : spm_switch_port_mapping_tb_top
